// ---- src/irq_cause_pkg.sv ----
// Constants for the interrupt cause and request line map block.
// Assumes a 32-bit AXI4-Lite register bus and 25 MHz system clock.
package irq_cause_pkg;
    localparam int GROUP_COUNT = 64;
    localparam int LINES_PER_GROUP = 32;
    localparam int LINE_COUNT = GROUP_COUNT * LINES_PER_GROUP;
    localparam int LEVEL_COUNT = 4;
    localparam int LEVEL_WIDTH = 2;
    localparam int CAUSE_WIDTH = 6;
    localparam int ADDR_WIDTH = 12;
    localparam int DATA_WIDTH = 32;

    // Register byte offsets; cause offsets run from level 3 down to 0
    localparam logic [11:0] CAUSE_FIRST_OFFSET = 12'h200;
    localparam logic [11:0] CAUSE_LAST_OFFSET = 12'h20c;
    localparam logic [11:0] HOLD_CTRL_OFFSET = 12'h210;
    localparam logic [11:0] LEVEL_STATUS_OFFSET = 12'h214;

    // Reset values
    localparam logic [5:0] CAUSE_RESET = 6'h00;
    localparam logic HOLD_RESET = 1'b0;
    localparam int HOLD_BIT = 0;

    // Fixed request line placement
    localparam int GPIO_GROUP = 18;
    localparam int GPIO_LINE_COUNT = 16;
    localparam int CAN_GROUP = 9;
    localparam int CAN_CHANNEL_STRIDE = 5;
    localparam int CAN_BUS_OFF_LINE = 0;
    localparam int CAN_ERROR_LINE = 1;
    localparam int CAN_RX_LINE = 2;
    localparam int CAN_TX_LINE = 3;
    localparam int CAN_WAKE_LINE = 4;
    localparam int CONVERTER_GROUP = 36;
    localparam int CONV_SEQUENCER_ZERO_DONE_LINE = 0;
    localparam int CONV_SEQUENCER_ONE_DONE_LINE = 1;
    localparam int CONV_STARTUP_LINE = 2;
    localparam int CONV_WINDOW_LINE = 3;
    localparam int CONV_WAKE_LINE = 4;
    localparam int CONV_PEN_LINE = 5;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- src/cause_finder.sv ----
// Finds the lowest-numbered pending group assigned to one level.
// Assumes pending and level vectors are stable within the cycle.
`timescale 1ns/1ps
module cause_finder #(
    parameter int GROUPS = 64,
    parameter logic [1:0] LEVEL = 2'h0
) (
    input wire logic [GROUPS-1:0] groupPending,
    input wire logic [2*GROUPS-1:0] groupLevel,
    output logic found,
    output logic [5:0] group
);
    // RULE10 lowest number wins
    always_comb begin
        found = 1'b0;
        group = 6'h00;
        for (int g = GROUPS - 1; g >= 0; g--) begin
            if (groupPending[g] && groupLevel[2*g +: 2] == LEVEL) begin
                found = 1'b1;
                group = 6'(g);
            end
        end
    end
endmodule

// ---- src/interrupt_cause_and_line_map.sv ----
// Per-level cause registers and fixed request line map, AXI4-Lite slave.
// Assumes group levels come from the priority registers outside and all
// request inputs are synchronous to clk.
`timescale 1ns/1ps

// Notes on behaviour
// RULE1 - Four read-only cause words, six-bit group field
// RULE2 - Cause names top-priority pending group at level
// RULE3 - Cause meaningless when level has nothing pending
// RULE4 - Up to 64 groups, numbered as cause
// RULE5 - Up to 32 lines in each group
// RULE6 - Group lines share one level, one offset
// RULE7 - Pin requests on group 18, lines 0-15
// RULE8 - CAN requests on group 9, lines 0-9
// RULE9 - Converter requests on group 36, lines 0-5
// RULE10 - Tie at level: lowest group number wins
// RULE11 - Cause reads harmless, cause writes ignored
module interrupt_cause_and_line_map (
    input wire logic clk,
    input wire logic rst,
    input wire logic [irq_cause_pkg::LINE_COUNT-1:0] otherRequestLines,
    input wire logic [2*irq_cause_pkg::GROUP_COUNT-1:0] groupPriorityLevel,
    input wire logic [15:0] gpioRequest,
    input wire logic [1:0] busOffRequest,
    input wire logic [1:0] canErrorRequest,
    input wire logic [1:0] receiveDoneRequest,
    input wire logic [1:0] transmitDoneRequest,
    input wire logic [1:0] canWakeRequest,
    input wire logic sequencerZeroDone,
    input wire logic sequencerOneDone,
    input wire logic startupDoneRequest,
    input wire logic windowMatchRequest,
    input wire logic converterWakeRequest,
    input wire logic penDetectRequest,
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [3:0] levelPending
);
    localparam int GROUPS = irq_cause_pkg::GROUP_COUNT;
    localparam int LPG = irq_cause_pkg::LINES_PER_GROUP;
    localparam int CW = irq_cause_pkg::CAUSE_WIDTH;

    logic [irq_cause_pkg::LINE_COUNT-1:0] allLines;
    logic [GROUPS-1:0] groupPending;
    logic [3:0] found;
    logic [CW-1:0] foundGroup [4];
    logic [CW-1:0] cause [4];
    logic [CW-1:0] next_cause [4];
    logic [3:0] next_levelPending;
    logic holdCause, next_holdCause;
    logic awHeld, next_awHeld, wHeld, next_wHeld;
    logic [11:0] awAddrReg, next_awAddrReg;
    logic [31:0] wDataReg, next_wDataReg;
    logic [3:0] wStrbReg, next_wStrbReg;
    logic next_awready, next_wready, next_bvalid, next_arready;
    logic next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // RULE7 pin requests placed
    // RULE8 CAN requests placed
    // RULE9 converter requests placed
    always_comb begin
        allLines = otherRequestLines;
        allLines[irq_cause_pkg::GPIO_GROUP*LPG +:
                 irq_cause_pkg::GPIO_LINE_COUNT] = gpioRequest;
        for (int c = 0; c < 2; c++) begin
            allLines[irq_cause_pkg::CAN_GROUP*LPG
                     + c*irq_cause_pkg::CAN_CHANNEL_STRIDE
                     + irq_cause_pkg::CAN_BUS_OFF_LINE] = busOffRequest[c];
            allLines[irq_cause_pkg::CAN_GROUP*LPG
                     + c*irq_cause_pkg::CAN_CHANNEL_STRIDE
                     + irq_cause_pkg::CAN_ERROR_LINE] = canErrorRequest[c];
            allLines[irq_cause_pkg::CAN_GROUP*LPG
                     + c*irq_cause_pkg::CAN_CHANNEL_STRIDE
                     + irq_cause_pkg::CAN_RX_LINE] = receiveDoneRequest[c];
            allLines[irq_cause_pkg::CAN_GROUP*LPG
                     + c*irq_cause_pkg::CAN_CHANNEL_STRIDE
                     + irq_cause_pkg::CAN_TX_LINE] = transmitDoneRequest[c];
            allLines[irq_cause_pkg::CAN_GROUP*LPG
                     + c*irq_cause_pkg::CAN_CHANNEL_STRIDE
                     + irq_cause_pkg::CAN_WAKE_LINE] = canWakeRequest[c];
        end
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_SEQUENCER_ZERO_DONE_LINE] = sequencerZeroDone;
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_SEQUENCER_ONE_DONE_LINE] = sequencerOneDone;
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_STARTUP_LINE] = startupDoneRequest;
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_WINDOW_LINE] = windowMatchRequest;
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_WAKE_LINE] = converterWakeRequest;
        allLines[irq_cause_pkg::CONVERTER_GROUP*LPG
                 + irq_cause_pkg::CONV_PEN_LINE] = penDetectRequest;
    end

    // RULE4 group count
    // RULE5 lines per group
    // RULE6 any line raises its group
    always_comb begin
        for (int g = 0; g < GROUPS; g++) begin
            groupPending[g] = |allLines[g*LPG +: LPG];
        end
    end

    for (genvar l = 0; l < irq_cause_pkg::LEVEL_COUNT; l++) begin : g_lvl
        cause_finder #(.GROUPS(GROUPS), .LEVEL(2'(l))) u_finder (
            .groupPending(groupPending),
            .groupLevel(groupPriorityLevel),
            .found(found[l]),
            .group(foundGroup[l])
        );
    end

    // RULE2 track winning group
    // RULE3 hold last value when idle
    always_comb begin
        for (int l = 0; l < 4; l++) begin
            next_cause[l] = (found[l] && !holdCause) ? foundGroup[l]
                                                      : cause[l];
        end
        next_levelPending = found;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int l = 0; l < 4; l++) begin
                cause[l] <= irq_cause_pkg::CAUSE_RESET;
            end
            levelPending <= 4'h0;
        end else begin
            cause <= next_cause;
            levelPending <= next_levelPending;
        end
    end

    function automatic logic isCause(input logic [11:0] a);
        isCause = a >= irq_cause_pkg::CAUSE_FIRST_OFFSET &&
                  a <= irq_cause_pkg::CAUSE_LAST_OFFSET && a[1:0] == 2'h0;
    endfunction

    // Bus slave; hold control freezes the cause words for a coherent scan
    always_comb begin
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddrReg = awAddrReg;
        next_wDataReg = wDataReg;
        next_wStrbReg = wStrbReg;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_holdCause = holdCause;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_awHeld = 1'b1;
            next_awAddrReg = awaddr;
        end
        if (wvalid && wready) begin
            next_wHeld = 1'b1;
            next_wDataReg = wdata;
            next_wStrbReg = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (next_awHeld && next_wHeld && !next_bvalid) begin
            next_awHeld = 1'b0;
            next_wHeld = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = irq_cause_pkg::RESP_OKAY;
            // RULE11 cause writes dropped
            if (next_awAddrReg == irq_cause_pkg::HOLD_CTRL_OFFSET) begin
                if (next_wStrbReg[0]) begin
                    next_holdCause = next_wDataReg[irq_cause_pkg::HOLD_BIT];
                end
            end else if (!isCause(next_awAddrReg) && next_awAddrReg
                         != irq_cause_pkg::LEVEL_STATUS_OFFSET) begin
                next_bresp = irq_cause_pkg::RESP_SLVERR;
            end
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = irq_cause_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            // RULE1 six-bit field, rest zero
            if (isCause(araddr)) begin
                next_rdata[CW-1:0] = cause[2'h3 - araddr[3:2]];
            end else if (araddr == irq_cause_pkg::HOLD_CTRL_OFFSET) begin
                next_rdata[irq_cause_pkg::HOLD_BIT] = holdCause;
            end else if (araddr == irq_cause_pkg::LEVEL_STATUS_OFFSET) begin
                next_rdata[3:0] = levelPending;
            end else begin
                next_rresp = irq_cause_pkg::RESP_SLVERR;
            end
        end
        next_awready = !next_awHeld && !next_bvalid;
        next_wready = !next_wHeld && !next_bvalid;
        next_arready = !next_rvalid;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 12'h000;
            wDataReg <= 32'h0000_0000;
            wStrbReg <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
            holdCause <= irq_cause_pkg::HOLD_RESET;
        end else begin
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddrReg <= next_awAddrReg;
            wDataReg <= next_wDataReg;
            wStrbReg <= next_wStrbReg;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            holdCause <= next_holdCause;
        end
    end

    sequence s_cause_read;
        arvalid && arready && isCause(araddr);
    endsequence
    property p_cause_reserved_zero;
        @(posedge clk) disable iff (rst)
        s_cause_read |=> rvalid && rdata[31:6] == 26'h0 && rresp == 2'h0;
    endproperty
    a_cause_reserved_zero: assert property (p_cause_reserved_zero) // RULE1
        else $error("cause read has nonzero reserved bits");

    property p_gpio_map;
        @(posedge clk) disable iff (rst)
        groupPending[18] == (|gpioRequest | |otherRequestLines[607:592]);
    endproperty
    a_gpio_map: assert property (p_gpio_map) // RULE7
        else $error("pin requests not seen on group 18");

    property p_can_map;
        @(posedge clk) disable iff (rst)
        allLines[297:288] == {canWakeRequest[1], transmitDoneRequest[1],
            receiveDoneRequest[1], canErrorRequest[1], busOffRequest[1],
            canWakeRequest[0], transmitDoneRequest[0],
            receiveDoneRequest[0], canErrorRequest[0], busOffRequest[0]};
    endproperty
    a_can_map: assert property (p_can_map) // RULE8
        else $error("CAN lines misplaced in group 9");

    property p_conv_map;
        @(posedge clk) disable iff (rst)
        allLines[1157:1152] == {penDetectRequest, converterWakeRequest,
            windowMatchRequest, startupDoneRequest, sequencerOneDone,
            sequencerZeroDone};
    endproperty
    a_conv_map: assert property (p_conv_map) // RULE9
        else $error("converter lines misplaced in group 36");

    property p_write_ignored;
        @(posedge clk) disable iff (rst)
        awvalid && awready && isCause(awaddr) |=>
            ##[0:2] (bvalid && bresp == 2'h0) ##1 $stable(holdCause);
    endproperty
    a_write_ignored: assert property (p_write_ignored) // RULE11
        else $error("cause write had an effect or bad response");

    for (genvar l = 0; l < 4; l++) begin : g_chk
        logic lowerHit;
        always_comb begin
            lowerHit = 1'b0;
            for (int g = 0; g < GROUPS; g++) begin
                if (g < int'(foundGroup[l]) && groupPending[g] &&
                    groupPriorityLevel[2*g +: 2] == 2'(l)) begin
                    lowerHit = 1'b1;
                end
            end
        end
        property p_cause_tracks;
            @(posedge clk) disable iff (rst)
            found[l] && !holdCause |=> cause[l] == $past(foundGroup[l]) &&
                levelPending[l];
        endproperty
        a_cause_tracks: assert property (p_cause_tracks) // RULE2
            else $error("cause does not follow pending group");
        property p_found_valid;
            @(posedge clk) disable iff (rst)
            found[l] |-> groupPending[foundGroup[l]] &&
                groupPriorityLevel[2*foundGroup[l] +: 2] == 2'(l);
        endproperty
        a_found_valid: assert property (p_found_valid) // RULE6
            else $error("chosen group not pending at level");
        property p_lowest_wins;
            @(posedge clk) disable iff (rst)
            found[l] |-> !lowerHit;
        endproperty
        a_lowest_wins: assert property (p_lowest_wins) // RULE10
            else $error("lower pending group skipped");
        property p_idle_hold;
            @(posedge clk) disable iff (rst)
            !found[l] |=> $stable(cause[l]) && !levelPending[l];
        endproperty
        a_idle_hold: assert property (p_idle_hold) // RULE3
            else $error("idle level cause changed");
    end
endmodule

// ---- test/core_model.sv ----
// Processor core side model: takes the per-level pending flags as requests.
// Assumes flags are synchronous to clk; the core answers nothing back.
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] levelPending,
    output logic [1:0] topLevel,
    output logic anyReq
);
    logic [1:0] next_topLevel;

    always_comb begin
        next_topLevel = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (levelPending[l]) begin
                next_topLevel = 2'(l);
            end
        end
    end

    // Core sees the request one clock after the block
    always_ff @(posedge clk) begin
        if (rst) begin
            topLevel <= 2'h0;
            anyReq <= 1'b0;
        end else begin
            topLevel <= next_topLevel;
            anyReq <= |levelPending;
        end
    end
endmodule

// ---- test/interrupt_cause_and_line_map_test.sv ----
// Self-checking bench for the cause registers and request line map.
// Assumes the design package and the core model are compiled first.
`timescale 1ns/1ps
`define CHK(a, b, m) begin numChecks++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, b); end end
module interrupt_cause_and_line_map_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [irq_cause_pkg::LINE_COUNT-1:0] otherRequestLines, tmp;
    logic [2*irq_cause_pkg::GROUP_COUNT-1:0] groupPriorityLevel;
    logic [31:0] ded, wdata, rdata;
    logic [15:0] gpioRequest;
    logic [1:0] busOffRequest, canErrorRequest, receiveDoneRequest;
    logic [1:0] transmitDoneRequest, canWakeRequest, bresp, rresp, coreTop;
    logic sequencerZeroDone, sequencerOneDone, startupDoneRequest;
    logic windowMatchRequest, converterWakeRequest, penDetectRequest;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, coreAny;
    logic [11:0] awaddr, araddr;
    logic [3:0] wstrb, levelPending;
    int fails = 0;
    int numChecks = 0;

    always #20 clk = ~clk;

    // Dedicated lines packed as 16 pin, 10 CAN, 6 converter bits
    assign gpioRequest = ded[15:0];
    assign busOffRequest = {ded[21], ded[16]};
    assign canErrorRequest = {ded[22], ded[17]};
    assign receiveDoneRequest = {ded[23], ded[18]};
    assign transmitDoneRequest = {ded[24], ded[19]};
    assign canWakeRequest = {ded[25], ded[20]};
    assign {penDetectRequest, converterWakeRequest, windowMatchRequest,
        startupDoneRequest, sequencerOneDone, sequencerZeroDone} = ded[31:26];

    interrupt_cause_and_line_map u_dut (
        .clk, .rst, .otherRequestLines, .groupPriorityLevel, .gpioRequest,
        .busOffRequest, .canErrorRequest, .receiveDoneRequest,
        .transmitDoneRequest, .canWakeRequest, .sequencerZeroDone,
        .sequencerOneDone, .startupDoneRequest, .windowMatchRequest,
        .converterWakeRequest, .penDetectRequest, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .levelPending
    );

    core_model u_core (
        .clk, .rst, .levelPending, .topLevel(coreTop), .anyReq(coreAny)
    );

    // Lowest pending group at a level, bit 6 flags that one exists
    function automatic logic [6:0] expCause(input int lvl);
        logic [irq_cause_pkg::LINE_COUNT-1:0] r;
        r = otherRequestLines;
        r[18*32 +: 16] = ded[15:0];
        r[9*32 +: 10] = ded[25:16];
        r[36*32 +: 6] = ded[31:26];
        for (int g = 0; g < 64; g++) begin
            if ((|r[32*g +: 32]) &&
                groupPriorityLevel[2*g +: 2] == 2'(lvl)) begin
                return {1'b1, 6'(g)};
            end
        end
        return 7'h0;
    endfunction

    function automatic logic [127:0] rndLevels();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
        output logic [1:0] r);
        @(posedge clk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
        output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge clk);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        bready <= 1'b1;
        while (aw || w) begin
            @(posedge clk);
            if (aw && awready === 1'b1) begin
                aw = 1'b0;
                awvalid <= 1'b0;
            end
            if (w && wready === 1'b1) begin
                w = 1'b0;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic checkAll();
        logic [31:0] d;
        logic [1:0] rs;
        logic [6:0] e;
        repeat (3) @(posedge clk);
        for (int l = 0; l < 4; l++) begin
            e = expCause(l);
            axiRead(12'h200 + 12'(4 * (3 - l)), d, rs);
            `CHK(rs, 2'h0, "cause resp")
            `CHK(levelPending[l], e[6], "level pending")
            if (e[6]) `CHK(d, {26'h0, e[5:0]}, "cause")
        end
    endtask

    task automatic setReq(input logic [irq_cause_pkg::LINE_COUNT-1:0] o,
        input logic [31:0] dd, input logic [127:0] lv);
        @(posedge clk);
        otherRequestLines <= o;
        ded <= dd;
        groupPriorityLevel <= lv;
        checkAll();
    endtask

    task automatic stopTest();
        $display("checks=%0d mismatches=%0d", numChecks, fails);
        if (fails == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stopTest();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] rs;
        {otherRequestLines, groupPriorityLevel, ded, tmp} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(32'hc0ca));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 5; a++) begin
            axiRead(12'h200 + 12'(4 * a), d, rs);
            `CHK(d, 32'h0, "reset value")
        end
        tmp[0] = 1'b1;
        tmp[2047] = 1'b1;
        setReq(tmp, '0, '1);
        `CHK({coreAny, coreTop}, 3'h7, "core level")
        tmp[0] = 1'b0;
        setReq(tmp, '0, '1);
        // shared slice ignored, line 31 kept
        tmp = '0;
        tmp[18*32 +: 16] = '1;
        setReq(tmp, '0, '1);
        tmp[18*32+31] = 1'b1;
        setReq(tmp, '0, '1);
        for (int k = 0; k < 32; k++) begin
            setReq('0, 32'h1 << k, rndLevels());
        end
        axiWrite(12'h20c, 32'hffffffff, rs);
        `CHK(rs, 2'h0, "cause write resp")
        checkAll();
        axiRead(12'h300, d, rs);
        `CHK({rs, d}, {2'h2, 32'h0}, "unmapped read")
        axiWrite(12'h400, 32'h1, rs);
        `CHK(rs, 2'h2, "unmapped write")
        // Hold freezes cause words; mid-run reset clears hold
        tmp = '0;
        tmp[5*32] = 1'b1;
        setReq(tmp, '0, '0);
        axiWrite(12'h210, 32'h1, rs);
        `CHK(rs, 2'h0, "hold write resp")
        tmp[5*32] = 1'b0;
        tmp[7*32] = 1'b1;
        otherRequestLines <= tmp;
        repeat (3) @(posedge clk);
        axiRead(12'h20c, d, rs);
        `CHK(d, 32'h5, "frozen cause")
        axiRead(12'h214, d, rs);
        `CHK(d, 32'h1, "level status")
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axiRead(12'h210, d, rs);
        `CHK(d, 32'h0, "hold after reset")
        checkAll();
        repeat (40) begin
            tmp = '0;
            repeat (3) tmp[$urandom_range(2047, 0)] = 1'b1;
            setReq(tmp, $urandom & $urandom, rndLevels());
        end
        stopTest();
    end
endmodule
